// file: include/tsm_map.vh
// Register offsets, field positions, reset values and timing counts of the triple stepper core.
// Overview of operation
// - Each motor picks one of four modes.
// - Trapezoid mode ramps autonomously to goal position.
// - New goal position accepted during motion.
// - Smooth mode decelerates along exponential curve.
// - Limited mode chases goal speed within limits.
// - Direct mode applies goal speed, ignoring limits.
// - Interrupt only for conditions enabled in mask.
// - Every host datagram returns status bits.
// - Default map: switches a,b,c left of 1,2,3.
// - Alternate map: c is motor one right.
// - Driver replies captured in two 24-bit registers.
// - Longer driver frames keep only last 48 bits.
// - Host datagram holds address, rw bit, data.
// - Reply shifts out while request shifts in.
// - Host datagrams are exactly 32 bits.
// - Select and driver data polarity invertible.
// - Positions and speeds are signed.
// - Speed and accel limits are unsigned.
// - Driver bit rate at most clock/16.
`ifndef TSM_MAP_VH
`define TSM_MAP_VH
// ****************************************************************
// Word indices (byte address is four times the index)
// ****************************************************************
`define TSM_M_GOAL_POS 3'd0
`define TSM_M_CUR_POS 3'd1
`define TSM_M_GOAL_SPD 3'd2
`define TSM_M_CUR_SPD 3'd3
`define TSM_M_SPD_FLOOR 3'd4
`define TSM_M_SPD_CEIL 3'd5
`define TSM_M_ACC_CEIL 3'd6
`define TSM_M_MODE 3'd7
`define TSM_G_CONFIG 3'd0
`define TSM_G_MASK 3'd1
`define TSM_G_STATUS 3'd2
`define TSM_G_TX_LO 3'd3
`define TSM_G_TX_HI 3'd4
`define TSM_G_LEN 3'd5
`define TSM_G_RX_LO 3'd6
`define TSM_G_RX_HI 3'd7
`define TSM_GLOBAL_BANK 2'd3
// ****************************************************************
// Fields and encodings
// ****************************************************************
`define TSM_CFG_SWMAP 0
`define TSM_CFG_INV_SEL 1
`define TSM_CFG_INV_DATA 2
`define TSM_MODE_TRAP 2'd0
`define TSM_MODE_SMOOTH 2'd1
`define TSM_MODE_LIMITED 2'd2
`define TSM_MODE_DIRECT 2'd3
`define TSM_HDG_RW 24
`define TSM_HDG_LAST 5'd31
`define TSM_DRV_MAX_LEN 7'd64
// ****************************************************************
// Reset values and timing
// ****************************************************************
`define TSM_RST_FLOOR 11'h001
`define TSM_RST_CEIL 11'h100
`define TSM_RST_ACC 11'h010
`define TSM_RST_MASK 7'h00
`define TSM_DRV_RATIO 16
`define TSM_DRV_HALF (`TSM_DRV_RATIO / 2)
`define TSM_RAMP_DIV 1000
`endif

// file: core/tsm_core.v
// Triple stepper motion core with host datagram port, driver chain port and APB registers.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "tsm_map.vh"
module tsm_core #(
  parameter RAMP_DIV = `TSM_RAMP_DIV,
  parameter DRV_HALF = `TSM_DRV_HALF
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire CLK_EN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire HOST_PORT_SELECT_N,
  input wire HOST_SCK,
  input wire HOST_SDI,
  output wire HOST_SDO,
  output wire HOST_SDO_OE_N,
  input wire HOME_SWITCH_A,
  input wire HOME_SWITCH_B,
  input wire HOME_SWITCH_C,
  output wire DRIVER_CHAIN_SELECT_N,
  output wire DRV_SCK,
  output wire DRV_SDO,
  input wire DRV_SDI,
  output wire [2:0] STEP,
  output wire [2:0] DIR,
  output reg IRQ_N
);
  // ****************************************************************
  // Register file
  // ****************************************************************
  reg signed [23:0] gpos [0:2];
  reg signed [11:0] gspd [0:2];
  reg [10:0] vmin [0:2];
  reg [10:0] vmax [0:2];
  reg [10:0] amax [0:2];
  reg [1:0] mode [0:2];
  reg [2:0] cfg;
  reg [6:0] mask;
  reg [6:0] status;
  reg [31:0] tx_lo;
  reg [31:0] tx_hi;
  reg [6:0] dlen;
  reg [23:0] rx_lo;
  reg [23:0] rx_hi;
  reg signed [23:0] pos [0:2];
  reg signed [11:0] spd [0:2];
  reg [15:0] phase [0:2];
  reg [2:0] stp;
  reg [2:0] reach_d;
  reg [2:0] sw_d;
  reg [9:0] tick;
  reg busy;
  reg drv_done;
  reg [3:0] dcnt;
  reg dsck;
  reg [6:0] dbits;
  reg [63:0] dtx;
  reg [47:0] drx;
  reg [6:0] pin_s1;
  reg [6:0] pin_s2;
  reg sck_d;
  reg cs_d;
  reg [4:0] hcnt;
  reg [30:0] hrx;
  reg [31:0] htx;
  reg [31:0] hrd;
  reg pend;
  reg [4:0] pidx;
  reg [23:0] pdat;
  integer m, n, j;

  function [31:0] rd;
    input [4:0] i;
    reg [1:0] k;
    begin
      k = i[4:3];
      rd = 32'h00000000;
      if (k != `TSM_GLOBAL_BANK) begin
        case (i[2:0])
          `TSM_M_GOAL_POS: rd = {{8{gpos[k][23]}}, gpos[k]};
          `TSM_M_CUR_POS: rd = {{8{pos[k][23]}}, pos[k]};
          `TSM_M_GOAL_SPD: rd = {{20{gspd[k][11]}}, gspd[k]};
          `TSM_M_CUR_SPD: rd = {{20{spd[k][11]}}, spd[k]};
          `TSM_M_SPD_FLOOR: rd = {21'h000000, vmin[k]};
          `TSM_M_SPD_CEIL: rd = {21'h000000, vmax[k]};
          `TSM_M_ACC_CEIL: rd = {21'h000000, amax[k]};
          default: rd = {30'h00000000, mode[k]};
        endcase
      end else begin
        case (i[2:0])
          `TSM_G_CONFIG: rd = {29'h00000000, cfg};
          `TSM_G_MASK: rd = {25'h0000000, mask};
          `TSM_G_STATUS: rd = {24'h000000, busy, status};
          `TSM_G_TX_LO: rd = tx_lo;
          `TSM_G_TX_HI: rd = tx_hi;
          `TSM_G_LEN: rd = {25'h0000000, dlen};
          `TSM_G_RX_LO: rd = {8'h00, rx_lo};
          default: rd = {8'h00, rx_hi};
        endcase
      end
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1 <= 7'h01;
      pin_s2 <= 7'h01;
    end else if (CLK_EN) begin
      pin_s1 <= {DRV_SDI, HOME_SWITCH_C, HOME_SWITCH_B, HOME_SWITCH_A, HOST_SDI, HOST_SCK, HOST_PORT_SELECT_N};
      pin_s2 <= pin_s1;
    end
  end
  wire cs_act = ~pin_s2[0];
  wire sck_rise = pin_s2[1] & ~sck_d;
  wire sck_fall = ~pin_s2[1] & sck_d;
  wire [2:0] lft = {pin_s2[5] & ~cfg[`TSM_CFG_SWMAP], pin_s2[4], pin_s2[3]};
  wire [2:0] rgt = {2'b00, pin_s2[5] & cfg[`TSM_CFG_SWMAP]};
  wire inv_d = cfg[`TSM_CFG_INV_DATA];

  // ****************************************************************
  // APB slave
  // ****************************************************************
  wire bad = PADDR[7] | (PADDR[1:0] != 2'b00);
  wire [4:0] apb_idx = PADDR[6:2];
  wire apb_wr = PSEL & PENABLE & PWRITE & ~bad;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & bad;
  wire wr = apb_wr | pend;
  wire [4:0] widx = apb_wr ? apb_idx : pidx;
  wire [31:0] wdat = apb_wr ? PWDATA : {8'h00, pdat};
  wire wglob = widx[4:3] == `TSM_GLOBAL_BANK;
  wire [6:0] clr = (wr && wglob && widx[2:0] == `TSM_G_STATUS) ? wdat[6:0] : 7'h00;
  wire drv_go = wr && wglob && widx[2:0] == `TSM_G_LEN && !busy && wdat[6:0] != 7'h00 &&
                wdat[6:0] <= `TSM_DRV_MAX_LEN;
  wire [31:0] hdg = {hrx, pin_s2[2]};
  wire [2:0] reach;
  wire [2:0] sw_lvl = lft | rgt;
  wire [6:0] ev = {drv_done, sw_lvl & ~sw_d, reach & ~reach_d};

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
    end else if (CLK_EN && PSEL && !PENABLE) begin
      PRDATA <= bad ? 32'h00000000 : rd(apb_idx);
    end
  end

  // ****************************************************************
  // Registers, status flags and host datagram port
  // ****************************************************************
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (j = 0; j < 3; j = j + 1) begin
        gpos[j] <= 24'h000000;
        gspd[j] <= 12'h000;
        vmin[j] <= `TSM_RST_FLOOR;
        vmax[j] <= `TSM_RST_CEIL;
        amax[j] <= `TSM_RST_ACC;
        mode[j] <= `TSM_MODE_TRAP;
      end
      cfg <= 3'h0;
      mask <= `TSM_RST_MASK;
      status <= 7'h00;
      tx_lo <= 32'h00000000;
      tx_hi <= 32'h00000000;
      dlen <= 7'h00;
      IRQ_N <= 1'b1;
      sck_d <= 1'b0;
      cs_d <= 1'b0;
      hcnt <= 5'h00;
      hrx <= 31'h00000000;
      htx <= 32'h00000000;
      hrd <= 32'h00000000;
      pend <= 1'b0;
      pidx <= 5'h00;
      pdat <= 24'h000000;
    end else if (CLK_EN) begin
      status <= (status & ~clr) | ev;
      IRQ_N <= ~|(status & mask);
      sck_d <= pin_s2[1];
      cs_d <= cs_act;
      if (!apb_wr) begin
        pend <= 1'b0;
      end
      if (wr && !wglob) begin
        case (widx[2:0])
          `TSM_M_GOAL_POS: gpos[widx[4:3]] <= wdat[23:0];
          `TSM_M_GOAL_SPD: gspd[widx[4:3]] <= wdat[11:0];
          `TSM_M_SPD_FLOOR: vmin[widx[4:3]] <= wdat[10:0];
          `TSM_M_SPD_CEIL: vmax[widx[4:3]] <= wdat[10:0];
          `TSM_M_ACC_CEIL: amax[widx[4:3]] <= wdat[10:0];
          `TSM_M_MODE: mode[widx[4:3]] <= wdat[1:0];
          default: ;
        endcase
      end else if (wr) begin
        case (widx[2:0])
          `TSM_G_CONFIG: cfg <= wdat[2:0];
          `TSM_G_MASK: mask <= wdat[6:0];
          `TSM_G_TX_LO: tx_lo <= wdat;
          `TSM_G_TX_HI: tx_hi <= wdat;
          `TSM_G_LEN: if (!busy) dlen <= wdat[6:0];
          default: ;
        endcase
      end
      // A host write waits here while the APB owns the write port, so neither is lost.
      if (!cs_act) begin
        hcnt <= 5'h00;
      end else begin
        if (cs_act && !cs_d) begin
          htx <= {~IRQ_N, status, hrd[23:0]};
        end else if (sck_fall) begin
          htx <= {htx[30:0], 1'b0};
        end
        if (sck_rise) begin
          hrx <= hdg[30:0];
          hcnt <= hcnt + 5'd1;
          if (hcnt == `TSM_HDG_LAST) begin
            if (hdg[`TSM_HDG_RW]) begin
              hrd <= (hdg[31:30] == 2'b00) ? rd(hdg[29:25]) : 32'h00000000;
            end else if (hdg[31:30] == 2'b00) begin
              pend <= 1'b1;
              pidx <= hdg[29:25];
              pdat <= hdg[23:0];
            end
          end
        end
      end
    end
  end
  assign HOST_SDO = htx[31];
  assign HOST_SDO_OE_N = pin_s2[0];

  // ****************************************************************
  // Motion engines
  // ****************************************************************
  reg signed [11:0] nsp [0:2];
  reg [15:0] nph [0:2];
  reg [2:0] ncy;
  reg signed [23:0] d;
  reg [23:0] ad;
  reg [11:0] mg;
  reg [11:0] mt;
  reg signed [11:0] tg;
  reg signed [11:0] lm;
  reg signed [11:0] fl;
  reg signed [12:0] df;
  reg [10:0] st;
  reg [35:0] e_kin;
  reg [35:0] e_brk;
  wire tick_hit = tick == RAMP_DIV - 1;

  always @* begin
    ncy = 3'b000;
    d = 24'h000000;
    ad = 24'h000000;
    mg = 12'h000;
    mt = 12'h000;
    tg = 12'h000;
    lm = 12'h000;
    fl = 12'h000;
    df = 13'h0000;
    st = 11'h000;
    e_kin = 36'h000000000;
    e_brk = 36'h000000000;
    for (m = 0; m < 3; m = m + 1) begin
      d = gpos[m] - pos[m];
      ad = d[23] ? -d : d;
      mg = spd[m][11] ? -spd[m] : spd[m];
      lm = {1'b0, vmax[m]};
      fl = {1'b0, vmin[m]};
      e_kin = mg * mg;
      e_brk = {ad, 1'b0} * amax[m];
      case (mode[m])
        `TSM_MODE_TRAP, `TSM_MODE_SMOOTH: begin
          // Brake once v*v reaches 2*a*distance, the classic trapezoid turn point.
          tg = (d != 24'h000000 && e_kin < e_brk) ? (d[23] ? -lm : lm) : 12'h000;
        end
        `TSM_MODE_LIMITED: tg = (gspd[m] > lm) ? lm : ((gspd[m] < -lm) ? -lm : gspd[m]);
        default: tg = gspd[m];
      endcase
      if ((tg < 0 && lft[m]) || (tg > 0 && rgt[m])) begin
        tg = 12'h000;
      end
      mt = tg[11] ? -tg : tg;
      st = amax[m];
      if (mode[m] == `TSM_MODE_SMOOTH && (mt < mg || (tg[11] ^ spd[m][11]))) begin
        st = mg[11:1] / 11'd4 + 11'd1;
      end
      df = {tg[11], tg} - {spd[m][11], spd[m]};
      nsp[m] = spd[m];
      if (mode[m] == `TSM_MODE_DIRECT) begin
        nsp[m] = tg;
      end else if (mode[m][1] == 1'b0 && d == 24'h000000) begin
        nsp[m] = 12'h000;
      end else if (tick_hit) begin
        if (spd[m] == 12'h000 && tg != 12'h000 && {1'b0, vmin[m]} <= mt) begin
          nsp[m] = tg[11] ? -fl : fl;
        end else if (df > $signed({2'b00, st})) begin
          nsp[m] = spd[m] + $signed({1'b0, st});
        end else if (df < -$signed({2'b00, st})) begin
          nsp[m] = spd[m] - $signed({1'b0, st});
        end else begin
          nsp[m] = tg;
        end
      end
      {ncy[m], nph[m]} = {1'b0, phase[m]} + {5'h00, mg};
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (n = 0; n < 3; n = n + 1) begin
        pos[n] <= 24'h000000;
        spd[n] <= 12'h000;
        phase[n] <= 16'h0000;
      end
      stp <= 3'b000;
      tick <= 10'h000;
      reach_d <= 3'b000;
      sw_d <= 3'b000;
    end else if (CLK_EN) begin
      tick <= tick_hit ? 10'h000 : tick + 10'h001;
      reach_d <= reach;
      sw_d <= sw_lvl;
      stp <= ncy;
      for (n = 0; n < 3; n = n + 1) begin
        spd[n] <= nsp[n];
        phase[n] <= nph[n];
        if (ncy[n]) begin
          pos[n] <= spd[n][11] ? pos[n] - 24'sd1 : pos[n] + 24'sd1;
        end
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_mot
      assign reach[g] = ~mode[g][1] && pos[g] == gpos[g] && spd[g] == 12'h000;
      assign DIR[g] = ~spd[g][11];
    end
  endgenerate
  assign STEP = stp;

  // ****************************************************************
  // Driver chain shifter
  // ****************************************************************
  // Half period of DRV_HALF cycles caps the bit rate at clock/16 by default.
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy <= 1'b0;
      drv_done <= 1'b0;
      dcnt <= 4'h0;
      dsck <= 1'b0;
      dbits <= 7'h00;
      dtx <= 64'h0000000000000000;
      drx <= 48'h000000000000;
      rx_lo <= 24'h000000;
      rx_hi <= 24'h000000;
    end else if (CLK_EN) begin
      drv_done <= 1'b0;
      if (!busy) begin
        if (drv_go) begin
          busy <= 1'b1;
          dtx <= {tx_hi, tx_lo} << (`TSM_DRV_MAX_LEN - wdat[6:0]);
          drx <= 48'h000000000000;
          dbits <= 7'h00;
          dcnt <= 4'h0;
          dsck <= 1'b0;
        end
      end else if (dcnt == DRV_HALF - 1) begin
        dcnt <= 4'h0;
        dsck <= ~dsck;
        if (!dsck) begin
          drx <= {drx[46:0], pin_s2[6] ^ inv_d};
          dbits <= dbits + 7'h01;
        end else if (dbits == dlen) begin
          busy <= 1'b0;
          drv_done <= 1'b1;
          rx_lo <= drx[23:0];
          rx_hi <= drx[47:24];
        end else begin
          dtx <= {dtx[62:0], 1'b0};
        end
      end else begin
        dcnt <= dcnt + 4'h1;
      end
    end
  end
  assign DRV_SCK = dsck;
  assign DRV_SDO = dtx[63] ^ inv_d;
  assign DRIVER_CHAIN_SELECT_N = ~busy ^ cfg[`TSM_CFG_INV_SEL];
endmodule // tsm_core

// file: testbench/tsm_core_asserts.sv
// Port-level checks for the triple stepper core.
`timescale 1ns/1ps
module tsm_core_asserts #(
  parameter RAMP_DIV = 1000,
  parameter DRV_HALF = 8
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PSLVERR,
  input wire HOST_PORT_SELECT_N,
  input wire HOST_SDO_OE_N,
  input wire DRIVER_CHAIN_SELECT_N,
  input wire DRV_SCK,
  input wire DRV_SDO,
  input wire [2:0] STEP,
  input wire IRQ_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // The mask resets to zero, so until a non-zero mask lands the interrupt must stay quiet.
  logic mask_set;
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      mask_set <= 1'b0;
    else if (PSEL && PENABLE && PWRITE && PADDR == 8'h64 && PWDATA[6:0] != 7'h00)
      mask_set <= 1'b1;
  end
  sequence s_sel_on;
    $fell(HOST_PORT_SELECT_N);
  endsequence
  sequence s_oe_on;
    ##[1:4] !HOST_SDO_OE_N;
  endsequence
  property p_oe_on;
    s_sel_on |-> s_oe_on;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("reply driver not enabled after select");
  property p_oe_off;
    HOST_PORT_SELECT_N [*4] |-> HOST_SDO_OE_N;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("reply driver on while deselected");
  property p_half;
    $changed(DRV_SCK) |=> $stable(DRV_SCK) [*7];
  endproperty
  a_half: assert property (p_half) else $error("driver clock half period too short");
  property p_sdo;
    $changed(DRV_SDO) |-> !DRV_SCK;
  endproperty
  a_sdo: assert property (p_sdo) else $error("driver data moved while clock high");
  property p_rst;
    $rose(RST_N) |-> DRIVER_CHAIN_SELECT_N && !DRV_SCK && IRQ_N && STEP == 3'b000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_irq;
    !mask_set |-> IRQ_N;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt with empty mask");
  property p_step;
    STEP != 3'b000 |=> (STEP & $past(STEP)) == 3'b000;
  endproperty
  a_step: assert property (p_step) else $error("step pulse longer than one cycle");
  property p_err;
    PSEL && PENABLE && (PADDR[7] || PADDR[1:0] != 2'b00) |-> PSLVERR;
  endproperty
  a_err: assert property (p_err) else $error("bad address not refused");
  property p_ok;
    PSEL && PENABLE && !PADDR[7] && PADDR[1:0] == 2'b00 |-> !PSLVERR;
  endproperty
  a_ok: assert property (p_ok) else $error("good address refused");
endmodule // tsm_core_asserts
bind tsm_core tsm_core_asserts #(.RAMP_DIV(RAMP_DIV), .DRV_HALF(DRV_HALF)) i_tsm_core_asserts (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
  .HOST_PORT_SELECT_N(HOST_PORT_SELECT_N), .HOST_SDO_OE_N(HOST_SDO_OE_N), .DRIVER_CHAIN_SELECT_N(DRIVER_CHAIN_SELECT_N),
  .DRV_SCK(DRV_SCK), .DRV_SDO(DRV_SDO), .STEP(STEP), .IRQ_N(IRQ_N));

// file: testbench/tsm_host_model.sv
// Host controller on the four-wire datagram link.
`timescale 1ns/1ps
module tsm_host_model (
  output logic sel_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // The link clock stands low between frames; released data shows the inverse of its last bit.
  task xfer(input logic [31:0] tx, output logic [31:0] rx);
    int i;
    #3 sel_n = 1'b0;
    #120;
    for (i = 31; i >= 0; i--) begin
      sdi = tx[i];
      #40 sck = 1'b1;
      rx[i] = sdo;
      #40 sck = 1'b0;
    end
    #40 sel_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule // tsm_host_model

// file: testbench/tb.sv
// Self-checking bench for the triple stepper core.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  logic REF_CLK, se;
  logic RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, DRV_SDI = 1'b0, ha = 1'b0, hb = 1'b0, hc = 1'b0;
  logic psck = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, r, v, rx;
  logic [63:0] tx, pat = 64'h0, sent = 64'h0, m, e;
  logic [2:0] cfg = 3'h0;
  logic [32:0] q[$];
  int err_total = 0, comparisons = 0, seed = 21, k, nbits = 0, pidx = 63;
  wire [31:0] PRDATA;
  wire [2:0] STEP, DIR;
  wire PREADY, PSLVERR, HOST_SDO, HOST_SDO_OE_N, DRIVER_CHAIN_SELECT_N, DRV_SCK, DRV_SDO, IRQ_N, sel_n, sck, sdi;
  wire miso = HOST_SDO_OE_N ? 1'bz : HOST_SDO;
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  tsm_core #(.RAMP_DIV(10), .DRV_HALF(8)) i_tsm_core (.REF_CLK(REF_CLK), .RST_N(RST_N), .CLK_EN(1'b1), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .HOST_PORT_SELECT_N(sel_n), .HOST_SCK(sck), .HOST_SDI(sdi), .HOST_SDO(HOST_SDO),
    .HOST_SDO_OE_N(HOST_SDO_OE_N), .HOME_SWITCH_A(ha), .HOME_SWITCH_B(hb), .HOME_SWITCH_C(hc),
    .DRIVER_CHAIN_SELECT_N(DRIVER_CHAIN_SELECT_N), .DRV_SCK(DRV_SCK), .DRV_SDO(DRV_SDO), .DRV_SDI(DRV_SDI),
    .STEP(STEP), .DIR(DIR), .IRQ_N(IRQ_N));
  tsm_host_model i_tsm_host_model (.sel_n(sel_n), .sck(sck), .sdi(sdi), .sdo(miso));
  // ****************************************************************
  // Result watcher and driver chain
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && q.size() > 0) begin
      if (q[0][32])
        `CHK(PRDATA, q[0][31:0])
      void'(q.pop_front());
    end
  end
  always @(posedge REF_CLK) begin
    psck <= DRV_SCK;
    if ((DRIVER_CHAIN_SELECT_N ^ cfg[1]) !== 1'b0) begin
      DRV_SDI <= ~DRV_SDI;
      pidx <= 63;
    end else begin
      DRV_SDI <= pat[pidx];
      if (!psck && DRV_SCK)
        sent <= {sent[62:0], DRV_SDO};
      if (!psck && DRV_SCK)
        nbits <= nbits + 1;
      if (psck && !DRV_SCK)
        pidx <= pidx - 1;
    end
  end
  task conclude;
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    t = 0;
    do begin
      @(posedge REF_CLK);
      t++;
    end while (PREADY !== 1'b1 && t < 50);
    if (PREADY !== 1'b1) begin
      err_total++;
      conclude();
    end
    r = PRDATA;
    se = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic c);
    q.push_back({c, x});
    apb(1'b0, a, 32'h0);
  endtask
  task wt(input int c);
    repeat (c) @(posedge REF_CLK);
  endtask
  task poll(input logic [31:0] b);
    int t;
    t = 0;
    do begin
      rd(8'h68, 32'h0, 1'b0);
      t++;
    end while ((r & b) !== b && t < 4000);
    if ((r & b) !== b) begin
      err_total++;
      conclude();
    end
  endtask
  task hx(input logic [31:0] d);
    i_tsm_host_model.xfer(d, rx);
    @(posedge REF_CLK);
  endtask
  initial begin
    #900000;
    err_total++;
    conclude();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    for (k = 0; k < 3; k++) begin
      rd(8'(k * 32 + 16), 32'h1, 1'b1);
      rd(8'(k * 32 + 20), 32'h100, 1'b1);
      rd(8'(k * 32 + 24), 32'h10, 1'b1);
      rd(8'(k * 32 + 28), 32'h0, 1'b1);
    end
    rd(8'h64, 32'h0, 1'b1);
    for (k = 0; k < 4; k++) begin
      wr(8'((k % 3) * 32 + 28), 32'(k));
      rd(8'((k % 3) * 32 + 28), 32'(k), 1'b1);
      wr(8'((k % 3) * 32 + 28), 32'h0);
    end
    v = $random(seed);
    wr(8'h08, v);
    rd(8'h08, {{20{v[11]}}, v[11:0]}, 1'b1);
    wr(8'h08, 32'h0);
    rd(8'h80, 32'h0, 1'b1);
    `CHK(se, 1'b1)
    rd(8'h21, 32'h0, 1'b1);
    `CHK(se, 1'b1)
    // A read request is answered in the frame that follows it.
    rd(8'h68, 32'h0, 1'b0);
    v = r;
    hx({7'd12, 1'b0, 24'h0007a5});
    rd(8'h30, 32'h7a5, 1'b1);
    hx({7'd12, 1'b1, 24'h0});
    hx({7'd12, 1'b1, 24'h0});
    `CHK(rx[23:0], 24'h0007a5)
    `CHK(rx[31:24], {1'b0, v[6:0]})
    // Full limits on motors one and two, else the reset ramp needs far more cycles than the run allows.
    for (k = 0; k < 6; k++)
      wr(8'((k / 3) * 32 + 16 + (k % 3) * 4), 32'h7ff);
    wr(8'h3c, 32'h1);
    wr(8'h00, 32'd40);
    wr(8'h20, 32'd40);
    wr(8'h68, 32'h7);
    wt(600);
    wr(8'h00, 32'd12);
    wr(8'h20, 32'd12);
    wt(20);
    poll(32'h3);
    rd(8'h04, 32'd12, 1'b1);
    rd(8'h24, 32'd12, 1'b1);
    wr(8'h48, 32'h7ff);
    wr(8'h5c, 32'h2);
    wt(400);
    rd(8'h4c, 32'h100, 1'b1);
    wr(8'h5c, 32'h3);
    wt(30);
    rd(8'h4c, 32'h7ff, 1'b1);
    k = 0;
    repeat (100) begin
      @(posedge REF_CLK);
      if (STEP[2] === 1'b1)
        k++;
    end
    `CHK(k > 0, 1'b1)
    `CHK(DIR[2], 1'b1)
    wr(8'h48, 32'h801);
    wt(30);
    `CHK(DIR[2], 1'b0)
    wr(8'h48, 32'h0);
    hc <= 1'b1;
    wt(6);
    rd(8'h68, 32'h0, 1'b0);
    `CHK(r[5:3], 3'b100)
    wr(8'h68, 32'h38);
    wr(8'h60, 32'h1);
    wt(4);
    rd(8'h68, 32'h0, 1'b0);
    `CHK(r[5:3], 3'b001)
    hc <= 1'b0;
    // Frames of 48 and 56 bits, the second with inverted select and data.
    for (k = 0; k < 2; k++) begin
      cfg = k ? 3'b110 : 3'b000;
      wr(8'h60, 32'(cfg));
      `CHK(DRIVER_CHAIN_SELECT_N, ~cfg[1])
      tx = {$random(seed), $random(seed)};
      pat = {$random(seed), $random(seed)};
      nbits = 0;
      wr(8'h6c, tx[31:0]);
      wr(8'h70, tx[63:32]);
      wr(8'h74, 32'(48 + 8 * k));
      poll(32'h40);
      `CHK(nbits, 48 + 8 * k)
      m = 64'hffffffffffffffff >> (16 - 8 * k);
      `CHK((sent ^ {64{cfg[2]}}) & m, tx & m)
      e = (pat >> (16 - 8 * k)) ^ {64{cfg[2]}};
      rd(8'h78, {8'h0, e[23:0]}, 1'b1);
      rd(8'h7c, {8'h0, e[47:24]}, 1'b1);
      `CHK(IRQ_N, 1'b1)
      wr(8'h64, 32'h40);
      wt(3);
      `CHK(IRQ_N, 1'b0)
      wr(8'h68, 32'h40);
      wt(3);
      `CHK(IRQ_N, 1'b1)
      wr(8'h64, 32'h0);
    end
    conclude();
  end
endmodule // tb
